// ### inc/ipl_pkg.sv
// package of register offsets, fields and constants for the input port level-change block
package ipl_pkg;
    localparam int IPL_NPINS = 4;
    localparam logic [11:0] IPL_OFS_LEVELS = 12'h000;
    localparam logic [11:0] IPL_OFS_MODE = 12'h010;
    localparam logic [11:0] IPL_OFS_CFG = 12'h011;
    localparam logic [11:0] IPL_OFS_IE = 12'h012;
    localparam int IPL_CFG_RATE_BIT = 0;
    localparam int IPL_CFG_POL_BIT = 1;
    localparam logic [3:0] IPL_MODE_RST = 4'h0;
    localparam logic [3:0] IPL_CFG_RST = 4'h0;
    localparam logic [3:0] IPL_IE_RST = 4'h0;
    localparam logic [3:0] IPL_CFG_RSVD = 4'hc;
    localparam logic [15:0] IPL_VECTOR = 16'h001e;
endpackage

// ### inc/ipl_samp_if.sv
// interface carrying the sampling controls and result between top and detector
`timescale 1ns/1ps
interface ipl_samp_if;
    logic sample_en;
    logic [3:0] pins;
    logic [3:0] enable;
    logic pol;
    logic change;
    modport ctl (output sample_en, output pins, output enable, output pol, input change);
    modport det (input sample_en, input pins, input enable, input pol, output change);
endinterface

// ### tb/ipl_pin_model.sv
// external drivers and pull resistors on the four input pins
`timescale 1ns/1ps
module ipl_pin_model (
    // bench drive
    input wire logic [3:0] drv_en,
    input wire logic [3:0] drv_val,
    // pull controls
    input wire logic [3:0] pull_en,
    input wire logic [3:0] pull_up,
    // pin levels
    output logic [3:0] pin_lvl
);
    // floating pins show the inverse of the last drive, never a stale level
    assign pin_lvl = (drv_en & drv_val) | (~drv_en & pull_en & pull_up) | (~drv_en & ~pull_en & ~drv_val);
endmodule

// ### tb/tb_top.sv
// self-checking bench for the four-pin input port
`timescale 1ns/1ps
module tb_top;
    import ipl_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] sfr_addr = 12'h000;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [3:0] sfr_wdata = 4'h0;
    logic tb_128hz = 1'b0;
    logic tb_4khz = 1'b0;
    logic flag_clear = 1'b0;
    logic [3:0] drv_en = 4'hf;
    logic [3:0] drv_val = 4'h0;
    logic [3:0] sfr_rdata, pin_in, pull_en, pull_up, rv, pulses;
    logic irq_req, irq_flag;
    logic [15:0] irq_vector;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 mclk = ~mclk;

    ipl_port dut_u (.mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tb_128hz(tb_128hz), .tb_4khz(tb_4khz),
        .pin_in(pin_in), .pull_en(pull_en), .pull_up(pull_up), .flag_clear(flag_clear),
        .level_change_irq_request(irq_req), .level_change_request_flag(irq_flag), .irq_vector(irq_vector));
    ipl_pin_model pins_u (.drv_en(drv_en), .drv_val(drv_val), .pull_en(pull_en), .pull_up(pull_up),
        .pin_lvl(pin_in));

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [3:0] exp);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        check(sfr_rdata, exp);
    endtask

    // one tap pulse, then count request pulses and check the sticky flag
    task automatic sample(input logic fast, input logic exp);
        @(negedge mclk);
        tb_4khz = fast;
        tb_128hz = !fast;
        @(negedge mclk);
        tb_4khz = 1'b0;
        tb_128hz = 1'b0;
        pulses = 4'h0;
        repeat (4)
        begin
            @(negedge mclk);
            pulses = pulses + {3'h0, irq_req};
        end
        check(pulses, exp);
        check(irq_flag, exp);
        flag_clear = 1'b1;
        @(negedge mclk);
        flag_clear = 1'b0;
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic reset_values();
        check(pull_en, 4'hf);
        check(pull_up, 4'h0);
        check(irq_vector, 16'h001e);
        rd(IPL_OFS_MODE, 4'h0);
        rd(IPL_OFS_CFG, 4'hc);
        rd(IPL_OFS_IE, 4'h0);
        rd(12'h013, 4'h0);
    endtask

    task automatic pull_and_levels();
        drv_val = 4'ha;
        rd(IPL_OFS_LEVELS, 4'ha);
        drv_en = 4'h0;
        rd(IPL_OFS_LEVELS, 4'h0);
        wr(IPL_OFS_CFG, 4'h3);
        wr(IPL_OFS_MODE, 4'h5);
        rd(IPL_OFS_CFG, 4'hf);
        check(pull_up, 4'hf);
        check(pull_en, 4'ha);
        drv_en = 4'h5;
        drv_val = 4'h0;
        rd(IPL_OFS_LEVELS, 4'ha);
        drv_en = 4'hf;
        wr(IPL_OFS_CFG, 4'h0);
        wr(IPL_OFS_MODE, 4'h0);
    endtask

    task automatic irq_pulldown();
        wr(IPL_OFS_IE, 4'hf);
        sample(1'b0, 1'b0);
        drv_val = 4'h2;
        repeat (4) @(negedge mclk);
        check(irq_flag, 1'b0);
        sample(1'b1, 1'b0);
        sample(1'b0, 1'b1);
        rd(IPL_OFS_LEVELS, 4'h2);
        drv_val = 4'h6;
        sample(1'b0, 1'b0);
        drv_val = 4'h0;
        sample(1'b0, 1'b1);
        wr(IPL_OFS_IE, 4'h1);
        drv_val = 4'h8;
        sample(1'b0, 1'b0);
        drv_val = 4'h0;
        wr(IPL_OFS_IE, 4'hf);
    endtask

    task automatic irq_pullup();
        drv_val = 4'hf;
        wr(IPL_OFS_CFG, 4'h3);
        sample(1'b1, 1'b0);
        drv_val = 4'hb;
        sample(1'b1, 1'b1);
        drv_val = 4'hf;
        sample(1'b0, 1'b0);
        sample(1'b1, 1'b1);
    endtask

    // change and clear in one cycle: the set must win
    task automatic set_beats_clear();
        drv_val = 4'h7;
        flag_clear = 1'b1;
        @(negedge mclk);
        tb_4khz = 1'b1;
        @(negedge mclk);
        tb_4khz = 1'b0;
        @(negedge mclk);
        check(irq_flag, 1'b1);
        @(negedge mclk);
        check(irq_flag, 1'b0);
        flag_clear = 1'b0;
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        reset_values();
        pull_and_levels();
        irq_pulldown();
        irq_pullup();
        set_beats_clear();
        tally_and_finish();
    end
endmodule

// ### verilog/ipl_detect.sv
// level-change detector sampled on the selected time-base clock edge
`timescale 1ns/1ps
module ipl_detect
    import ipl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // sampling link
    ipl_samp_if.det sif
);
    logic state_reg;
    logic state_next;
    logic primed_reg;
    logic [3:0] eff;

    // disabled pins sit at their idle level so they never move the combination
    always_comb
    begin
        eff = (sif.pins & sif.enable) | ({4{sif.pol}} & ~sif.enable);
        if (sif.pol)
            state_next = ~&eff;
        else
            state_next = |eff;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= 1'b0;
            primed_reg <= 1'b0;
        end
        else if (sif.sample_en)
        begin
            state_reg <= state_next;
            primed_reg <= 1'b1;
        end
    end

    assign sif.change = sif.sample_en && primed_reg && (state_next != state_reg);
endmodule

// ### verilog/ipl_port.sv
// four-pin input port with pull control and level-change interrupt request
`timescale 1ns/1ps
module ipl_port
    import ipl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // special function register access
    input wire logic [11:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [3:0] sfr_wdata,
    output logic [3:0] sfr_rdata,
    // time base taps
    input wire logic tb_128hz,
    input wire logic tb_4khz,
    // pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pull_en,
    output logic [3:0] pull_up,
    // interrupt controller
    input wire logic flag_clear,
    output logic level_change_irq_request,
    output logic level_change_request_flag,
    output logic [15:0] irq_vector
);
    logic [3:0] input_mode_select_reg;
    logic pull_polarity_select_reg;
    logic sampling_rate_select_reg;
    logic [3:0] pin_interrupt_enable_reg;
    logic tb_prev_reg;
    logic tb_sel;
    logic change;
    ipl_samp_if sif();

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    //------------------------------------------------------------
    // control registers
    //------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            input_mode_select_reg <= IPL_MODE_RST;
            pull_polarity_select_reg <= IPL_CFG_RST[IPL_CFG_POL_BIT];
            sampling_rate_select_reg <= IPL_CFG_RST[IPL_CFG_RATE_BIT];
            pin_interrupt_enable_reg <= IPL_IE_RST;
        end
        else if (sfr_wr)
        begin
            if (hit(sfr_addr, IPL_OFS_MODE))
                input_mode_select_reg <= sfr_wdata;
            if (hit(sfr_addr, IPL_OFS_CFG))
            begin
                pull_polarity_select_reg <= sfr_wdata[IPL_CFG_POL_BIT];
                sampling_rate_select_reg <= sfr_wdata[IPL_CFG_RATE_BIT];
            end
            if (hit(sfr_addr, IPL_OFS_IE))
                pin_interrupt_enable_reg <= sfr_wdata;
        end
    end

    //------------------------------------------------------------
    // read data
    //------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            sfr_rdata <= 4'h0;
        else if (sfr_rd)
        begin
            if (hit(sfr_addr, IPL_OFS_LEVELS))
                sfr_rdata <= pin_in;
            else if (hit(sfr_addr, IPL_OFS_MODE))
                sfr_rdata <= input_mode_select_reg;
            else if (hit(sfr_addr, IPL_OFS_CFG))
                sfr_rdata <= IPL_CFG_RSVD | {2'b00, pull_polarity_select_reg, sampling_rate_select_reg};
            else if (hit(sfr_addr, IPL_OFS_IE))
                sfr_rdata <= pin_interrupt_enable_reg;
            else
                sfr_rdata <= 4'h0;
        end
    end

    //------------------------------------------------------------
    // pad controls
    //------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pull_en <= 4'hf;
            pull_up <= 4'h0;
        end
        else
        begin
            pull_en <= ~input_mode_select_reg;
            pull_up <= {4{pull_polarity_select_reg}};
        end
    end

    //------------------------------------------------------------
    // sampling edge: falling edge of selected tap
    //------------------------------------------------------------
    assign tb_sel = sampling_rate_select_reg ? tb_4khz : tb_128hz;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tb_prev_reg <= 1'b0;
        else
            tb_prev_reg <= tb_sel;
    end

    assign sif.sample_en = tb_prev_reg && !tb_sel;
    assign sif.pins = pin_in;
    assign sif.enable = pin_interrupt_enable_reg;
    assign sif.pol = pull_polarity_select_reg;
    assign change = sif.change;

    ipl_detect u_det (
        .mclk(mclk),
        .rstn(rstn),
        .sif(sif)
    );

    //------------------------------------------------------------
    // request pulse and sticky flag; set wins over clear
    //------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            level_change_irq_request <= 1'b0;
            level_change_request_flag <= 1'b0;
            irq_vector <= IPL_VECTOR;
        end
        else
        begin
            level_change_irq_request <= change;
            if (change)
                level_change_request_flag <= 1'b1;
            else if (flag_clear)
                level_change_request_flag <= 1'b0;
            irq_vector <= IPL_VECTOR;
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence fall_s;
        tb_prev_reg && !tb_sel;
    endsequence

    flag_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        change |=> level_change_request_flag && level_change_irq_request)
        else $error("flag not set after change");
    only_on_edge_a: assert property (@(posedge mclk) disable iff (!rstn)
        change |-> fall_s)
        else $error("change outside sampling edge");
    flag_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        level_change_request_flag && !flag_clear |=> level_change_request_flag)
        else $error("flag dropped without clear");
    flag_cause_a: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(level_change_request_flag) |-> $past(change))
        else $error("flag rose without change");
    pull_map_a: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 pull_en == ~$past(input_mode_select_reg))
        else $error("pull enable mismatch");
    pull_dir_a: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 pull_up == {4{$past(pull_polarity_select_reg)}})
        else $error("pull direction mismatch");
    level_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        sfr_rd && sfr_addr == IPL_OFS_LEVELS |=> sfr_rdata == $past(pin_in))
        else $error("level readback wrong");
    masked_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        pin_interrupt_enable_reg == 4'h0 |-> !change)
        else $error("change with all pins disabled");
    vector_fixed_a: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 irq_vector == IPL_VECTOR)
        else $error("vector wrong");

    //------------------------------------------------------------
    // check helpers: independent copy of the sampled combination
    //------------------------------------------------------------
    logic [3:0] chk_eff;
    logic chk_any_high;
    logic chk_all_high;
    logic chk_state;
    logic chk_last_reg;
    logic chk_primed_reg;

    // disabled pins read as the idle level of the chosen pull
    always_comb
    begin
        chk_eff = pin_in;
        for (int i = 0; i < IPL_NPINS; i++)
        begin
            if (!pin_interrupt_enable_reg[i])
                chk_eff[i] = pull_polarity_select_reg;
        end
        chk_any_high = |chk_eff;
        chk_all_high = &chk_eff;
        chk_state = pull_polarity_select_reg ? !chk_all_high : chk_any_high;
    end

    // last sampled combination, kept apart from the detector
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            chk_last_reg <= 1'b0;
            chk_primed_reg <= 1'b0;
        end
        else if (sif.sample_en)
        begin
            chk_last_reg <= chk_state;
            chk_primed_reg <= 1'b1;
        end
    end

    sequence armed_s;
        tb_prev_reg && !tb_sel && chk_primed_reg;
    endsequence

    sequence pd_s;
        armed_s ##0 !pull_polarity_select_reg;
    endsequence

    sequence pu_s;
        armed_s ##0 pull_polarity_select_reg;
    endsequence

    //------------------------------------------------------------
    // checks: detection rules
    //------------------------------------------------------------
    pd_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
        pd_s ##0 (!chk_last_reg && chk_any_high) |-> change)
        else $error("no request on rise from all low");
    pd_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
        pd_s ##0 (chk_last_reg && !chk_any_high) |-> change)
        else $error("no request on fall to all low");
    pu_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
        pu_s ##0 (!chk_last_reg && !chk_all_high) |-> change)
        else $error("no request on fall from all high");
    pu_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
        pu_s ##0 (chk_last_reg && chk_all_high) |-> change)
        else $error("no request on rise to all high");
    no_false_a: assert property (@(posedge mclk) disable iff (!rstn)
        armed_s ##0 (chk_last_reg == chk_state) |-> !change)
        else $error("request without level change");

    //------------------------------------------------------------
    // checks: flag and registers
    //------------------------------------------------------------
    set_wins_a: assert property (@(posedge mclk) disable iff (!rstn)
        change && flag_clear |=> level_change_request_flag)
        else $error("clear beat a new request");
    flag_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        flag_clear && !change |=> !level_change_request_flag)
        else $error("flag not cleared");
    req_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        level_change_irq_request |=> !level_change_irq_request)
        else $error("request longer than one cycle");
    mode_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        sfr_wr && sfr_addr == IPL_OFS_MODE |=> input_mode_select_reg == $past(sfr_wdata))
        else $error("mode write lost");
    ie_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        sfr_wr && sfr_addr == IPL_OFS_IE |=> pin_interrupt_enable_reg == $past(sfr_wdata))
        else $error("enable write lost");
    cfg_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        sfr_wr && sfr_addr == IPL_OFS_CFG |=>
        {2'b00, pull_polarity_select_reg, sampling_rate_select_reg} == ($past(sfr_wdata) & ~IPL_CFG_RSVD))
        else $error("config write lost");
    cfg_rsvd_a: assert property (@(posedge mclk) disable iff (!rstn)
        sfr_rd && sfr_addr == IPL_OFS_CFG |=> (sfr_rdata & IPL_CFG_RSVD) == IPL_CFG_RSVD)
        else $error("reserved config bits not one");
    one_pull_a: assert property (@(posedge mclk) disable iff (!rstn)
        pull_up == {4{pull_up[0]}})
        else $error("pull polarity differs between pins");
endmodule
